// >>> hw/bsre_pkg.sv
// Constants and types for the boolean stack rung evaluator.
// Assumes a single 200 MHz clock with a synchronous active-high reset.
package bsre_pkg;

  localparam int unsigned STACK_LEVELS = 8;
  localparam int unsigned DEPTH_W = 4;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned BIT_SEL_W = 4;

  // Pause of an immediate physical I/O access
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned IMM_ACCESS_NS = 50;
  localparam int unsigned IMM_CYCLES =
    (IMM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned IMM_CNT_W = 8;

  localparam logic [1:0] ERR_NONE = 2'h0;
  localparam logic [1:0] ERR_OVERFLOW = 2'h1;
  localparam logic [1:0] ERR_UNDERFLOW = 2'h2;

  typedef enum logic [2:0] {
    OP_NOP = 3'h0,
    OP_STORE = 3'h1,
    OP_AND = 3'h2,
    OP_OR = 3'h3,
    OP_SERIES_MERGE = 3'h4,
    OP_PARALLEL_MERGE = 3'h5,
    OP_OUT = 3'h6,
    OP_END = 3'h7
  } bsre_op_t;

  typedef enum logic [2:0] {
    SRC_INPUT = 3'h0,
    SRC_OUTPUT = 3'h1,
    SRC_WORD_BIT = 3'h2,
    SRC_POINTER_BIT = 3'h3,
    SRC_COMPARE = 3'h4
  } bsre_src_t;

  typedef enum logic [1:0] {
    CMP_EQ = 2'h0,
    CMP_NE = 2'h1,
    CMP_GE = 2'h2,
    CMP_LT = 2'h3
  } bsre_cmp_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_IN_UPD = 3'h1,
    ST_FETCH = 3'h3,
    ST_MEM_WAIT = 3'h2,
    ST_PTR_WAIT = 3'h6,
    ST_IMM_WAIT = 3'h7,
    ST_OUT_UPD = 3'h5,
    ST_FAULT = 3'h4
  } bsre_state_t;

endpackage : bsre_pkg

// >>> hw/bsre_stack.sv
// Eight-level boolean stack: push, modify top, merge top two levels.
// Assumes at most one operation strobe per cycle from the evaluator.
module bsre_stack #(
  parameter int unsigned DEPTH = bsre_pkg::STACK_LEVELS
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic push_i,
  input wire logic and_i,
  input wire logic or_i,
  input wire logic val_i,
  input wire logic merge_and_i,
  input wire logic merge_or_i,
  output logic top_o,
  output logic second_o,
  output logic [bsre_pkg::DEPTH_W-1:0] depth_o,
  output logic overflow_o,
  output logic underflow_o
);
  import bsre_pkg::*;

  logic [DEPTH-1:0] lvl_q;
  logic [DEPTH_W-1:0] depth_q;
  logic full;
  logic merge;
  logic merged;

  assign full = (depth_q == DEPTH_W'(DEPTH));
  assign merge = merge_and_i | merge_or_i;
  assign merged = merge_and_i ? (lvl_q[0] & lvl_q[1])
                              : (lvl_q[0] | lvl_q[1]);
  assign overflow_o = push_i & full;
  assign underflow_o = (merge & (depth_q < DEPTH_W'(2))) |
                       ((and_i | or_i) & (depth_q == '0));
  assign top_o = lvl_q[0];
  assign second_o = lvl_q[1];
  assign depth_o = depth_q;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || clear_i) begin
      lvl_q <= '0;
    end else if (push_i && !full) begin
      lvl_q <= {lvl_q[DEPTH-2:0], val_i}; // RULE1
    end else if (merge && !underflow_o) begin
      lvl_q <= {1'b0, lvl_q[DEPTH-1:2], merged}; // RULE4
    end else if (and_i && !underflow_o) begin
      lvl_q[0] <= lvl_q[0] & val_i; // RULE8
    end else if (or_i && !underflow_o) begin
      lvl_q[0] <= lvl_q[0] | val_i; // RULE9
    end
  end

  // Depth never passes the level count; a ninth push is refused
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || clear_i) begin
      depth_q <= '0;
    end else if (push_i && !full) begin
      depth_q <= depth_q + DEPTH_W'(1); // RULE2
    end else if (merge && !underflow_o) begin
      depth_q <= depth_q - DEPTH_W'(1);
    end
  end

endmodule : bsre_stack

// >>> hw/bsre_evaluator.sv
// Rung evaluator: scans boolean instructions against I/O image registers.
// Assumes a word memory with request/acknowledge reads and an instruction
// source that presents one instruction at a time with valid/ready.
// Notes on behaviour
// RULE1: store pushes contact, shifting stack down
// RULE2: stack holds exactly eight levels
// RULE3: ninth level is an error, rung not executed
// RULE4: merges AND or OR top two levels
// RULE5: store takes normally open point state
// RULE6: negated store takes inverted point state
// RULE7: word-bit contact picks bit 0-15, direct or pointer
// RULE8: AND contact ANDs into top
// RULE9: OR contact ORs into top
// RULE10: parallel negated contact ORs inverted state
// RULE11: compare BCD words: eq, ne, ge, lt
// RULE12: coil writes top into output image
// RULE13: coil keeps stack so rung continues
// RULE14: end marker stops program execution
// RULE15: regular I/O only in update phases
// RULE16: immediate access pauses execution
// RULE17: immediate input leaves input image untouched
// RULE18: immediate output writes pin and image
// RULE19: merge with under two levels is an error
module bsre_evaluator #(
  parameter int unsigned ADDR_W = 10,
  parameter int unsigned PT_W = 6
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic scan_start_i,
  input wire logic instr_valid_i,
  input wire bsre_pkg::bsre_op_t instr_op_i,
  input wire bsre_pkg::bsre_src_t instr_src_i,
  input wire bsre_pkg::bsre_cmp_t instr_cmp_i,
  input wire logic instr_neg_i,
  input wire logic instr_imm_i,
  input wire logic [ADDR_W-1:0] instr_addr_i,
  input wire logic [bsre_pkg::BIT_SEL_W-1:0] instr_bit_i,
  input wire logic [bsre_pkg::WORD_W-1:0] instr_k_i,
  output logic instr_ready_o,
  output logic mem_req_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic [bsre_pkg::WORD_W-1:0] mem_rdata_i,
  input wire logic [2**PT_W-1:0] io_in_i,
  output logic [2**PT_W-1:0] io_out_o,
  output logic scan_busy_o,
  output logic scan_done_o,
  output logic error_o,
  output logic [1:0] err_code_o
);
  import bsre_pkg::*;

  localparam int unsigned NPTS = 2**PT_W;

  bsre_state_t state_q;
  bsre_op_t op_q, s_op;
  bsre_src_t src_q, s_src;
  bsre_cmp_t cmp_q, s_cmp;
  logic neg_q, imm_q, s_neg, s_imm;
  logic [ADDR_W-1:0] addr_q, s_addr;
  logic [BIT_SEL_W-1:0] bit_q, s_bit;
  logic [WORD_W-1:0] k_q, s_k;
  logic [PT_W-1:0] s_pt;
  logic [NPTS-1:0] in_img_q, out_img_q, io_out_q;
  logic [IMM_CNT_W-1:0] imm_cnt_q;
  logic ready_q, mem_req_q, busy_q, done_q, err_q;
  logic [ADDR_W-1:0] mem_addr_q;
  logic [1:0] code_q;
  logic take, is_contact, needs_mem, needs_imm, exec;
  logic cmp_v, raw_v, contact_v;
  logic st_push, st_and, st_or, st_mand, st_mor, st_clear;
  logic top, second, ovf, unf, coil_unf;
  logic [DEPTH_W-1:0] depth;

  // Port fields in FETCH, latched copy while waiting
  assign s_op = (state_q == ST_FETCH) ? instr_op_i : op_q;
  assign s_src = (state_q == ST_FETCH) ? instr_src_i : src_q;
  assign s_cmp = (state_q == ST_FETCH) ? instr_cmp_i : cmp_q;
  assign s_neg = (state_q == ST_FETCH) ? instr_neg_i : neg_q;
  assign s_imm = (state_q == ST_FETCH) ? instr_imm_i : imm_q;
  assign s_addr = (state_q == ST_FETCH) ? instr_addr_i : addr_q;
  assign s_bit = (state_q == ST_FETCH) ? instr_bit_i : bit_q;
  assign s_k = (state_q == ST_FETCH) ? instr_k_i : k_q;
  assign s_pt = s_addr[PT_W-1:0];

  assign take = (state_q == ST_FETCH) && instr_valid_i && ready_q;
  assign is_contact = (s_op == OP_STORE) || (s_op == OP_AND) ||
                      (s_op == OP_OR);
  assign needs_mem = is_contact && (s_src == SRC_WORD_BIT ||
                     s_src == SRC_POINTER_BIT || s_src == SRC_COMPARE);
  assign needs_imm = s_imm && ((is_contact && s_src == SRC_INPUT) ||
                               s_op == OP_OUT);

  // Point where a contact or coil instruction completes
  always_comb begin
    unique case (state_q)
      ST_FETCH: exec = take && !needs_mem && !needs_imm &&
                       (is_contact || s_op == OP_OUT);
      ST_MEM_WAIT: exec = mem_ack_i && (src_q != SRC_POINTER_BIT);
      ST_PTR_WAIT: exec = mem_ack_i;
      ST_IMM_WAIT: exec = (imm_cnt_q == '0);
      default: exec = 1'b0;
    endcase
  end

  // Valid BCD orders like plain binary, so an unsigned compare suffices
  always_comb begin
    unique case (s_cmp)
      CMP_EQ: cmp_v = (mem_rdata_i == s_k); // RULE11
      CMP_NE: cmp_v = (mem_rdata_i != s_k); // RULE11
      CMP_GE: cmp_v = (mem_rdata_i >= s_k); // RULE11
      CMP_LT: cmp_v = (mem_rdata_i < s_k); // RULE11
    endcase
  end

  always_comb begin
    unique case (s_src)
      SRC_INPUT: raw_v = (state_q == ST_IMM_WAIT) ? io_in_i[s_pt]
                                                  : in_img_q[s_pt]; // RULE5
      SRC_OUTPUT: raw_v = out_img_q[s_pt]; // RULE5
      SRC_WORD_BIT: raw_v = mem_rdata_i[s_bit]; // RULE7
      SRC_POINTER_BIT: raw_v = mem_rdata_i[s_bit]; // RULE7
      SRC_COMPARE: raw_v = cmp_v;
      default: raw_v = 1'b0;
    endcase
  end

  assign contact_v = raw_v ^ s_neg; // RULE6 RULE10

  assign st_clear = (state_q == ST_IN_UPD);
  assign st_push = exec && (s_op == OP_STORE); // RULE1
  assign st_and = exec && (s_op == OP_AND); // RULE8
  assign st_or = exec && (s_op == OP_OR); // RULE9 RULE10
  assign st_mand = take && (s_op == OP_SERIES_MERGE); // RULE4
  assign st_mor = take && (s_op == OP_PARALLEL_MERGE); // RULE4
  assign coil_unf = exec && (s_op == OP_OUT) && (depth == '0);

  bsre_stack #(
    .DEPTH(STACK_LEVELS)
  ) u_stack (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .clear_i(st_clear),
    .push_i(st_push),
    .and_i(st_and),
    .or_i(st_or),
    .val_i(contact_v),
    .merge_and_i(st_mand),
    .merge_or_i(st_mor),
    .top_o(top),
    .second_o(second),
    .depth_o(depth),
    .overflow_o(ovf),
    .underflow_o(unf)
  );

  // Sequencer
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
    end else if (ovf || unf || coil_unf) begin
      state_q <= ST_FAULT; // RULE3 RULE19
    end else begin
      unique case (state_q)
        ST_IDLE, ST_FAULT: if (scan_start_i) state_q <= ST_IN_UPD;
        ST_IN_UPD: state_q <= ST_FETCH;
        ST_FETCH: begin
          if (take && s_op == OP_END) begin
            state_q <= ST_OUT_UPD; // RULE14
          end else if (take && needs_mem) begin
            state_q <= ST_MEM_WAIT;
          end else if (take && needs_imm) begin
            state_q <= ST_IMM_WAIT; // RULE16
          end
        end
        ST_MEM_WAIT: begin
          if (mem_ack_i && src_q == SRC_POINTER_BIT) begin
            state_q <= ST_PTR_WAIT; // RULE7
          end else if (mem_ack_i) begin
            state_q <= ST_FETCH;
          end
        end
        ST_PTR_WAIT: if (mem_ack_i) state_q <= ST_FETCH;
        ST_IMM_WAIT: if (imm_cnt_q == '0) state_q <= ST_FETCH;
        ST_OUT_UPD: state_q <= ST_IDLE;
      endcase
    end
  end

  // Instruction latch
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      op_q <= OP_NOP;
      src_q <= SRC_INPUT;
      cmp_q <= CMP_EQ;
      neg_q <= 1'b0;
      imm_q <= 1'b0;
      addr_q <= '0;
      bit_q <= '0;
      k_q <= '0;
    end else if (take) begin
      op_q <= instr_op_i;
      src_q <= instr_src_i;
      cmp_q <= instr_cmp_i;
      neg_q <= instr_neg_i;
      imm_q <= instr_imm_i;
      addr_q <= instr_addr_i;
      bit_q <= instr_bit_i;
      k_q <= instr_k_i;
    end
  end

  // Ready only in FETCH; dropped on an edge that leaves it
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ready_q <= 1'b0;
    end else if (ovf || unf || coil_unf) begin
      ready_q <= 1'b0;
    end else if (state_q == ST_FETCH) begin
      ready_q <= !(take && (s_op == OP_END || needs_mem || needs_imm));
    end else begin
      ready_q <= (state_q == ST_IN_UPD) ||
                 (state_q == ST_IMM_WAIT && imm_cnt_q == '0) ||
                 (state_q == ST_PTR_WAIT && mem_ack_i) ||
                 (state_q == ST_MEM_WAIT && mem_ack_i &&
                  src_q != SRC_POINTER_BIT);
    end
  end

  // Word reads; a pointer word becomes the address of the second read
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mem_req_q <= 1'b0;
      mem_addr_q <= '0;
    end else if (take && needs_mem) begin
      mem_req_q <= 1'b1;
      mem_addr_q <= instr_addr_i;
    end else if (state_q == ST_MEM_WAIT && mem_ack_i &&
                 src_q == SRC_POINTER_BIT) begin
      mem_req_q <= 1'b1;
      mem_addr_q <= mem_rdata_i[ADDR_W-1:0]; // RULE7
    end else if (mem_ack_i) begin
      mem_req_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      imm_cnt_q <= '0;
    end else if (take && needs_imm) begin
      imm_cnt_q <= IMM_CNT_W'(IMM_CYCLES - 1); // RULE16
    end else if (state_q == ST_IMM_WAIT && imm_cnt_q != '0) begin
      imm_cnt_q <= imm_cnt_q - IMM_CNT_W'(1);
    end
  end

  // Input image changes only in the input update phase
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      in_img_q <= '0;
    end else if (state_q == ST_IN_UPD) begin
      in_img_q <= io_in_i; // RULE15 RULE17
    end
  end

  // Coil leaves the stack alone so later contacts extend the rung
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      out_img_q <= '0;
    end else if (exec && s_op == OP_OUT && depth != '0) begin
      out_img_q[s_pt] <= top; // RULE12 RULE13 RULE18
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      io_out_q <= '0;
    end else if (state_q == ST_OUT_UPD) begin
      io_out_q <= out_img_q; // RULE15
    end else if (state_q == ST_IMM_WAIT && exec && op_q == OP_OUT &&
                 depth != '0) begin
      io_out_q[s_pt] <= top; // RULE18
    end
  end

  // Status; a fault holds until the next scan start
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
      code_q <= ERR_NONE;
    end else begin
      busy_q <= (state_q != ST_IDLE && state_q != ST_FAULT &&
                 state_q != ST_OUT_UPD) || scan_start_i;
      done_q <= (state_q == ST_OUT_UPD);
      if (ovf) begin
        err_q <= 1'b1;
        code_q <= ERR_OVERFLOW; // RULE3
      end else if (unf || coil_unf) begin
        err_q <= 1'b1;
        code_q <= ERR_UNDERFLOW; // RULE19
      end else if (state_q == ST_IN_UPD) begin
        err_q <= 1'b0;
        code_q <= ERR_NONE;
      end
    end
  end

  assign instr_ready_o = ready_q;
  assign mem_req_o = mem_req_q;
  assign mem_addr_o = mem_addr_q;
  assign io_out_o = io_out_q;
  assign scan_busy_o = busy_q;
  assign scan_done_o = done_q;
  assign error_o = err_q;
  assign err_code_o = code_q;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  push_depth_a: assert property (st_push && !ovf |=> // RULE1
    depth == $past(depth) + DEPTH_W'(1) && top == $past(contact_v))
    else $error("push did not add one level");
  depth_max_a: assert property (depth <= DEPTH_W'(8)) // RULE2
    else $error("stack deeper than eight");
  overflow_fault_a: assert property (ovf |=> // RULE3
    state_q == ST_FAULT && err_code_o == ERR_OVERFLOW && !instr_ready_o)
    else $error("overflow not faulted");
  merge_and_a: assert property (st_mand && depth >= DEPTH_W'(2) |=> // RULE4
    top == $past(top & second) && depth == $past(depth) - DEPTH_W'(1))
    else $error("series merge wrong");
  neg_store_a: assert property (st_push && s_neg && !ovf |=> // RULE6
    top == !$past(raw_v))
    else $error("negated store not inverted");
  and_contact_a: assert property (st_and && depth != '0 |=> // RULE8
    top == $past(top & contact_v))
    else $error("and contact wrong");
  or_contact_a: assert property (st_or && depth != '0 |=> // RULE9
    top == $past(top | contact_v))
    else $error("or contact wrong");
  coil_write_a: assert property (exec && s_op == OP_OUT && // RULE12
    depth != '0 |=> out_img_q[$past(s_pt)] == $past(top) &&
    depth == $past(depth))
    else $error("coil did not write image");
  end_stop_a: assert property (take && s_op == OP_END |=> // RULE14
    !instr_ready_o ##1 scan_done_o && !instr_ready_o)
    else $error("end marker did not stop");
  io_phase_a: assert property ($changed(io_out_q) |-> // RULE15
    $past(state_q) == ST_OUT_UPD || $past(state_q) == ST_IMM_WAIT)
    else $error("outputs changed outside update");
  imm_pause_a: assert property (take && needs_imm && !ovf |=> // RULE16
    !instr_ready_o [*8])
    else $error("immediate access did not pause");
  imm_image_a: assert property (state_q == ST_IMM_WAIT |=> // RULE17
    $stable(in_img_q))
    else $error("immediate input touched image");
  underflow_a: assert property ((st_mand || st_mor) && // RULE19
    depth < DEPTH_W'(2) |=> error_o && err_code_o == ERR_UNDERFLOW)
    else $error("merge underflow not flagged");

  full_stack_c: cover property (depth == DEPTH_W'(8));
  imm_out_c: cover property (exec && imm_q && op_q == OP_OUT);
  pointer_c: cover property (state_q == ST_PTR_WAIT && mem_ack_i);
  scan_done_c: cover property (scan_done_o && !error_o);

endmodule : bsre_evaluator

// >>> dv/bsre_mem_model.sv
// Word memory partner of the rung evaluator, answering fast or slow.
// Assumes mem_req_i is held by the evaluator until it sees the acknowledge.
module bsre_mem_model (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic mem_req_i,
  input wire logic [9:0] mem_addr_i,
  output logic mem_ack_o,
  output logic [bsre_pkg::WORD_W-1:0] mem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import bsre_pkg::*;
  logic [WORD_W-1:0] mem_q [0:15];
  logic [2:0] wait_q;
  initial begin
    foreach (mem_q[i]) mem_q[i] = 16'h0;
    mem_q[5] = 16'h8000;
    mem_q[6] = 16'h0007;
    mem_q[7] = 16'h0001;
    mem_q[8] = 16'h1234;
  end
  // Data is only valid with the acknowledge, so it toggles otherwise
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= 16'h0;
      wait_q <= 3'h0;
    end else begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
      if (mem_req_i && !mem_ack_o) begin
        if (wait_q == (slow_i ? 3'h4 : 3'h0)) begin
          mem_ack_o <= 1'b1;
          mem_rdata_o <= mem_q[mem_addr_i[3:0]];
          wait_q <= 3'h0;
        end else begin
          wait_q <= wait_q + 3'h1;
        end
      end
    end
  end
endmodule : bsre_mem_model

// >>> dv/test_boolean_stack_rung_evaluator.sv
// Self-checking bench for the rung evaluator with a memory partner.
// Assumes the evaluator's default widths: 10-bit addresses, 64 points.
module test_boolean_stack_rung_evaluator;
  timeunit 1ns;
  timeprecision 1ps;
  import bsre_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic scan_start_i = 1'b0;
  logic instr_valid_i = 1'b0;
  bsre_op_t instr_op_i = OP_NOP;
  bsre_src_t instr_src_i = SRC_INPUT;
  bsre_cmp_t instr_cmp_i = CMP_EQ;
  logic instr_neg_i = 1'b0;
  logic instr_imm_i = 1'b0;
  logic [9:0] instr_addr_i = 10'h0;
  logic [3:0] instr_bit_i = 4'h0;
  logic [15:0] instr_k_i = 16'h0;
  logic [63:0] io_in_i = 64'h0;
  logic slow = 1'b0;
  logic instr_ready_o, mem_req_o, mem_ack_o, scan_busy_o, scan_done_o;
  logic error_o;
  logic [9:0] mem_addr_o;
  logic [15:0] mem_rdata_o;
  logic [63:0] io_out_o;
  logic [1:0] err_code_o;
  logic [3:0] b_v = 4'h0;
  logic [15:0] k_v = 16'h0;
  bsre_cmp_t c_v = CMP_EQ;
  logic m_v = 1'b0;
  int err_total = 0;
  int total_checks = 0;
  int w;

  always #2.5 ref_clk_i = ~ref_clk_i;

  bsre_evaluator #(.ADDR_W(10), .PT_W(6)) dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .scan_start_i(scan_start_i),
    .instr_valid_i(instr_valid_i), .instr_op_i(instr_op_i),
    .instr_src_i(instr_src_i), .instr_cmp_i(instr_cmp_i),
    .instr_neg_i(instr_neg_i), .instr_imm_i(instr_imm_i),
    .instr_addr_i(instr_addr_i), .instr_bit_i(instr_bit_i),
    .instr_k_i(instr_k_i), .instr_ready_o(instr_ready_o),
    .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_o),
    .mem_rdata_i(mem_rdata_o), .io_in_i(io_in_i), .io_out_o(io_out_o),
    .scan_busy_o(scan_busy_o), .scan_done_o(scan_done_o),
    .error_o(error_o), .err_code_o(err_code_o));

  bsre_mem_model mdl (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .slow_i(slow),
    .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o),
    .mem_ack_o(mem_ack_o), .mem_rdata_o(mem_rdata_o));

  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", err_total, total_checks);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic chk_b(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t flag got %b exp %b", $time, got, exp);
    end
  endtask : chk_b

  task automatic chk_v(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t word got %h exp %h", $time, got, exp);
    end
  endtask : chk_v

  // Holds the instruction until the edge that takes it
  task automatic ins(input bsre_op_t op, input logic [9:0] a = 10'h0,
                     input logic n = 1'b0, input bsre_src_t s = SRC_INPUT);
    instr_valid_i <= 1'b1;
    instr_op_i <= op;
    instr_src_i <= s;
    instr_addr_i <= a;
    instr_neg_i <= n;
    instr_bit_i <= b_v;
    instr_k_i <= k_v;
    instr_cmp_i <= c_v;
    instr_imm_i <= m_v;
    w = 0;
    do begin
      @(posedge ref_clk_i);
      w++;
    end while (instr_ready_o !== 1'b1 && w < 40);
    chk_b(w < 40, 1'b1);
  endtask : ins

  task automatic start();
    @(posedge ref_clk_i);
    scan_start_i <= 1'b1;
    @(posedge ref_clk_i);
    scan_start_i <= 1'b0;
  endtask : start

  // A store stays offered after the end marker and must never be taken
  task automatic fin(input logic [63:0] mask, input logic [63:0] exp);
    int n;
    logic late;
    ins(OP_END);
    instr_op_i <= OP_STORE;
    late = 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
      late = late | instr_ready_o;
    end while (scan_done_o !== 1'b1 && n < 20);
    chk_b(late, 1'b0);
    chk_v(io_out_o & mask, exp);
    instr_valid_i <= 1'b0;
  endtask : fin

  task automatic t_contacts();
    io_in_i <= 64'h9;
    start();
    ins(OP_STORE, 0);
    chk_b(scan_busy_o, 1'b1);
    io_in_i <= 64'h0;
    ins(OP_AND, 3);
    ins(OP_OUT, 0);
    ins(OP_AND, 1);
    ins(OP_OUT, 1);
    ins(OP_STORE, 1, 1'b1);
    ins(OP_OUT, 2);
    ins(OP_STORE, 1);
    ins(OP_OR, 2);
    ins(OP_OUT, 3);
    ins(OP_OR, 0);
    ins(OP_OUT, 4);
    ins(OP_STORE, 1);
    ins(OP_OR, 3, 1'b1);
    ins(OP_OUT, 5);
    ins(OP_OR, 2, 1'b1);
    ins(OP_OUT, 6);
    ins(OP_STORE, 0);
    ins(OP_STORE, 3);
    ins(OP_STORE, 1);
    ins(OP_SERIES_MERGE);
    ins(OP_OUT, 7);
    ins(OP_PARALLEL_MERGE);
    ins(OP_OUT, 8);
    chk_v(io_out_o, 64'h0);
    fin(64'h1ff, 64'h155);
  endtask : t_contacts

  task automatic t_memory();
    start();
    b_v = 4'hf;
    ins(OP_STORE, 5, 1'b0, SRC_WORD_BIT);
    ins(OP_OUT, 10);
    b_v = 4'he;
    ins(OP_STORE, 5, 1'b0, SRC_WORD_BIT);
    ins(OP_OUT, 11);
    slow <= 1'b1;
    b_v = 4'h0;
    ins(OP_STORE, 6, 1'b1, SRC_POINTER_BIT);
    ins(OP_OUT, 12);
    for (int i = 0; i < 8; i++) begin
      c_v = bsre_cmp_t'(i[1:0]);
      k_v = (i < 4) ? 16'h1234 : 16'h1235;
      ins(OP_STORE, 8, 1'b0, SRC_COMPARE);
      ins(OP_OUT, 10'(16 + i));
      // Fold the spent level so eleven contacts fit in eight levels
      ins(OP_SERIES_MERGE);
    end
    slow <= 1'b0;
    fin(64'hff1c00, 64'ha50400);
  endtask : t_memory

  task automatic t_immediate();
    start();
    ins(OP_STORE, 4);
    ins(OP_OUT, 24);
    io_in_i <= 64'h10;
    m_v = 1'b1;
    ins(OP_STORE, 4);
    ins(OP_OUT, 25);
    chk_b(w > IMM_CYCLES, 1'b1);
    m_v = 1'b0;
    ins(OP_STORE, 4);
    chk_b(w > IMM_CYCLES, 1'b1);
    chk_b(io_out_o[25], 1'b1);
    ins(OP_OUT, 26);
    ins(OP_STORE, 25, 1'b0, SRC_OUTPUT);
    ins(OP_OUT, 27);
    fin(64'hf000000, 64'ha000000);
  endtask : t_immediate

  task automatic t_depth();
    start();
    for (int i = 0; i < 8; i++) ins(OP_STORE, 4);
    ins(OP_OUT, 27);
    fin(64'h8000000, 64'h8000000);
    chk_b(error_o, 1'b0);
    start();
    ins(OP_STORE, 4, 1'b1);
    ins(OP_OUT, 27);
    for (int i = 0; i < 8; i++) ins(OP_STORE, 4);
    instr_valid_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    chk_b(error_o, 1'b1);
    chk_v(64'(err_code_o), 64'(ERR_OVERFLOW));
    repeat (3) @(posedge ref_clk_i);
    chk_b(io_out_o[27], 1'b1);
  endtask : t_depth

  task automatic t_underflow();
    start();
    repeat (3) @(posedge ref_clk_i);
    chk_b(error_o, 1'b0);
    ins(OP_STORE, 4);
    ins(OP_SERIES_MERGE);
    instr_valid_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    chk_b(error_o, 1'b1);
    chk_v(64'(err_code_o), 64'(ERR_UNDERFLOW));
  endtask : t_underflow

  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    chk_b(instr_ready_o | scan_busy_o | error_o | mem_req_o, 1'b0);
    chk_v(io_out_o, 64'h0);
    t_contacts();
    t_memory();
    t_immediate();
    t_depth();
    t_underflow();
    end_of_test();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    err_total++;
    end_of_test();
  end
endmodule : test_boolean_stack_rung_evaluator
